/* src/lfp_top.sv */
// Lock byte, fuse bytes and extra-row select of the memory protection block,
// with the permission checks for programming interfaces and processor accesses.
// Assumes an Avalon-MM master on the core clock and interfaces that act only on grant.
module lfp_top #(
  parameter logic [7:0] LOCK_INIT = lfp_pkg::LFP_LOCK_RST,
  parameter logic [7:0] FEXT_INIT = lfp_pkg::LFP_FEXT_RST,
  parameter logic [7:0] FHIGH_INIT = lfp_pkg::LFP_FHIGH_RST,
  parameter logic [7:0] FLOW_INIT = lfp_pkg::LFP_FLOW_RST
) (
  // Clock and reset.
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // Avalon-MM register slave.
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  // Programming interface requests and answers.
  input wire lfp_pkg::lfp_prog_req_t PROG_REQ_I,
  output lfp_pkg::lfp_prog_rsp_t PROG_RSP_O,
  // Processor access checks.
  input wire lfp_pkg::lfp_cpu_req_t CPU_REQ_I,
  output lfp_pkg::lfp_cpu_perm_t CPU_PERM_O,
  // Extra-row selection.
  output logic [1:0] ROW_SEL_O,
  output logic ROW_USER_O,
  // Decoded fuse outputs.
  output logic [2:0] BROWNOUT_LEVEL_O,
  output logic DEBUG_EN_O,
  output logic JTAG_EN_O,
  output logic SERIAL_DL_EN_O,
  output logic WDOG_FORCED_O
);
  import lfp_pkg::*;

  // ==========================================================================
  // Decoding functions; all but lock_mode are used more than once.
  function automatic lfp_lock_mode_t lock_mode(input logic [7:0] lk);
    lfp_lock_mode_t m;
    m = LFP_MODE_NOVERIFY;
    if (lk[LFP_LOCK_MEM1] && lk[LFP_LOCK_MEM2])
      m = LFP_MODE_OPEN;
    else if (lk[LFP_LOCK_MEM2])
      m = LFP_MODE_NOPROG;
    return m;
  endfunction

  // A section pair blocks stores by its low bit and foreign loads by its high bit.
  function automatic logic pair_store_ok(input logic lo);
    return lo;
  endfunction

  function automatic logic pair_load_ok(input logic hi, input logic foreign);
    return hi | ~foreign;
  endfunction

  function automatic logic [7:0] read_byte(input logic [7:0] v);
    return v;
  endfunction

  // ==========================================================================
  // State.
  logic [7:0] row_ctrl_r;
  logic [7:0] lock_r;
  logic [7:0] lock_nxt;
  logic [7:0] fext_r;
  logic [7:0] fhigh_r;
  logic [7:0] flow_r;
  logic ack_r;
  logic [31:0] rdata_r;
  lfp_prog_rsp_t rsp_r;
  lfp_prog_rsp_t rsp_nxt;
  lfp_lock_mode_t mode;
  logic bus_req;
  logic bus_wr;
  logic fuse_locked;
  logic boot_locks_locked;
  logic prog_write_ok;
  logic prog_verify_ok;

  // ==========================================================================
  // Protection modes.
  always_comb
  begin
    mode = lock_mode(lock_r);
    fuse_locked = (mode != LFP_MODE_OPEN);
    boot_locks_locked = (mode == LFP_MODE_NOVERIFY);
    prog_write_ok = (mode == LFP_MODE_OPEN);
    prog_verify_ok = (mode != LFP_MODE_NOVERIFY);
  end

  // ==========================================================================
  // Avalon slave: one wait cycle, then the answer.
  assign bus_req = AVS_READ_I | AVS_WRITE_I;
  assign AVS_WAITREQUEST_O = bus_req & ~ack_r;
  assign AVS_READDATA_O = rdata_r;
  assign bus_wr = AVS_WRITE_I & ack_r & AVS_BYTEENABLE_I[0];

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      ack_r <= 1'b0;
    else
      ack_r <= bus_req & ~ack_r;
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      rdata_r <= 32'h0000_0000;
    else if (AVS_READ_I && !ack_r)
    begin
      case (AVS_ADDRESS_I)
        LFP_OFS_ROW_CTRL: rdata_r <= {24'h00_0000, read_byte(row_ctrl_r)};
        LFP_OFS_LOCK: rdata_r <= {24'h00_0000, read_byte(lock_r)};
        LFP_OFS_FUSE_EXT: rdata_r <= {24'h00_0000, read_byte(fext_r)};
        LFP_OFS_FUSE_HIGH: rdata_r <= {24'h00_0000, read_byte(fhigh_r)};
        LFP_OFS_FUSE_LOW: rdata_r <= {24'h00_0000, read_byte(flow_r)};
        LFP_OFS_STATUS: rdata_r <= {30'h0000_0000, mode};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Extra-row mode control.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      row_ctrl_r <= LFP_ROW_CTRL_RST;
    else if (bus_wr && AVS_ADDRESS_I == LFP_OFS_ROW_CTRL)
      row_ctrl_r <= AVS_WRITEDATA_I[7:0];
  end

  // With extended mode off only the factory row is reachable.
  always_comb
  begin
    if (row_ctrl_r[LFP_ROW_EN_BIT])
      ROW_SEL_O = row_ctrl_r[LFP_ROW_SEL_LSB +: 2];
    else
      ROW_SEL_O = LFP_ROW_FACTORY;
    ROW_USER_O = (ROW_SEL_O != LFP_ROW_FACTORY);
  end

  // ==========================================================================
  // Lock byte.
  // Writes can only clear bits, so a bit once programmed stays at 0 until erase or until reset loads LOCK_INIT.
  always_comb
  begin
    lock_nxt = lock_r;
    if (PROG_REQ_I.valid && PROG_REQ_I.cmd == LFP_CMD_CHIP_ERASE)
      lock_nxt = LFP_LOCK_RST;
    else if (PROG_REQ_I.valid && PROG_REQ_I.cmd == LFP_CMD_LOCK_WRITE)
    begin
      if (boot_locks_locked)
        lock_nxt = lock_r & (PROG_REQ_I.data | LFP_LOCK_BOOTPAIRS);
      else
        lock_nxt = lock_r & PROG_REQ_I.data;
    end
    else if (bus_wr && AVS_ADDRESS_I == LFP_OFS_LOCK)
      lock_nxt = lock_r & (AVS_WRITEDATA_I[7:0] | ~LFP_LOCK_BOOTPAIRS);
    lock_nxt = lock_nxt | LFP_LOCK_UNUSED;
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      lock_r <= LOCK_INIT;
    else
      lock_r <= lock_nxt;
  end

  // ==========================================================================
  // Fuse bytes.
  // A fuse write may set or clear bits; only the memory lock modes forbid it.
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      fext_r <= FEXT_INIT;
      fhigh_r <= FHIGH_INIT;
      flow_r <= FLOW_INIT;
    end
    else if (PROG_REQ_I.valid && !fuse_locked)
    begin
      case (PROG_REQ_I.cmd)
        LFP_CMD_FEXT_WRITE:
          fext_r <= (PROG_REQ_I.data & ~LFP_FEXT_KEEP) | (fext_r & LFP_FEXT_KEEP) | LFP_FEXT_UNUSED;
        LFP_CMD_FHIGH_WRITE: fhigh_r <= PROG_REQ_I.data;
        LFP_CMD_FLOW_WRITE: flow_r <= PROG_REQ_I.data;
        default:
        begin
          fext_r <= fext_r;
        end
      endcase
    end
  end

  // A programmed fuse reads 0, so each enable is the inverse of its bit.
  always_comb
  begin
    BROWNOUT_LEVEL_O = fext_r[2:0];
    DEBUG_EN_O = ~fhigh_r[LFP_FH_DEBUG];
    JTAG_EN_O = ~fhigh_r[LFP_FH_JTAG];
    SERIAL_DL_EN_O = ~fhigh_r[LFP_FH_SERIAL];
    WDOG_FORCED_O = ~fhigh_r[LFP_FH_WDOG];
  end

  // ==========================================================================
  // Programming interface answers, one cycle after the request.
  always_comb
  begin
    rsp_nxt.done = PROG_REQ_I.valid;
    rsp_nxt.denied = 1'b0;
    rsp_nxt.rdata = 8'hff;
    if (PROG_REQ_I.valid)
    begin
      case (PROG_REQ_I.cmd)
        LFP_CMD_FLASH_WRITE, LFP_CMD_EEPROM_WRITE: rsp_nxt.denied = ~prog_write_ok;
        LFP_CMD_FLASH_READ, LFP_CMD_EEPROM_READ: rsp_nxt.denied = ~prog_verify_ok;
        LFP_CMD_FEXT_WRITE, LFP_CMD_FHIGH_WRITE, LFP_CMD_FLOW_WRITE: rsp_nxt.denied = fuse_locked;
        LFP_CMD_LOCK_WRITE: rsp_nxt.denied = boot_locks_locked & ~(&(PROG_REQ_I.data | ~LFP_LOCK_BOOTPAIRS));
        LFP_CMD_LOCK_READ: rsp_nxt.rdata = lock_r;
        LFP_CMD_FEXT_READ: rsp_nxt.rdata = fext_r;
        LFP_CMD_FHIGH_READ: rsp_nxt.rdata = fhigh_r;
        LFP_CMD_FLOW_READ: rsp_nxt.rdata = flow_r;
        default: rsp_nxt.denied = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      rsp_r <= '{done: 1'b0, denied: 1'b0, rdata: 8'hff};
    else
      rsp_r <= rsp_nxt;
  end

  assign PROG_RSP_O = rsp_r;

  // ==========================================================================
  // Processor access permissions, checked against the live lock byte.
  // Combinational so that no access slips through during a lock change.
  always_comb
  begin
    if (CPU_REQ_I.target_boot)
    begin
      CPU_PERM_O.store_allow = CPU_REQ_I.store & pair_store_ok(lock_r[LFP_LOCK_BOOT_LO]);
      CPU_PERM_O.load_allow = CPU_REQ_I.load & pair_load_ok(lock_r[LFP_LOCK_BOOT_HI], ~CPU_REQ_I.exec_boot);
    end
    else
    begin
      CPU_PERM_O.store_allow = CPU_REQ_I.store & pair_store_ok(lock_r[LFP_LOCK_APP_LO]);
      CPU_PERM_O.load_allow = CPU_REQ_I.load & pair_load_ok(lock_r[LFP_LOCK_APP_HI], CPU_REQ_I.exec_boot);
    end
    CPU_PERM_O.irq_mask = (~CPU_REQ_I.exec_boot & CPU_REQ_I.vectors_boot & ~lock_r[LFP_LOCK_APP_HI])
      | (CPU_REQ_I.exec_boot & ~CPU_REQ_I.vectors_boot & ~lock_r[LFP_LOCK_BOOT_HI]);
  end

endmodule // lfp_top

/* src/lfp_pkg.sv */
// Package of the lock and fuse protection block: register map, field positions,
// reset values and the carrier types of the programming and processor ports.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package lfp_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [7:0] LFP_OFS_ROW_CTRL = 8'h00;
  localparam logic [7:0] LFP_OFS_LOCK = 8'h04;
  localparam logic [7:0] LFP_OFS_FUSE_EXT = 8'h08;
  localparam logic [7:0] LFP_OFS_FUSE_HIGH = 8'h0c;
  localparam logic [7:0] LFP_OFS_FUSE_LOW = 8'h10;
  localparam logic [7:0] LFP_OFS_STATUS = 8'h14;

  // ==========================================================================
  // Extra-row mode control fields.
  localparam int LFP_ROW_EN_BIT = 6;
  localparam int LFP_ROW_SEL_LSB = 4;
  localparam logic [7:0] LFP_ROW_CTRL_RST = 8'h0a;
  localparam logic [1:0] LFP_ROW_FACTORY = 2'h0;

  // ==========================================================================
  // Lock byte fields.
  localparam int LFP_LOCK_MEM1 = 0;
  localparam int LFP_LOCK_MEM2 = 1;
  localparam int LFP_LOCK_APP_LO = 2;
  localparam int LFP_LOCK_APP_HI = 3;
  localparam int LFP_LOCK_BOOT_LO = 4;
  localparam int LFP_LOCK_BOOT_HI = 5;
  localparam logic [7:0] LFP_LOCK_UNUSED = 8'hc0;
  localparam logic [7:0] LFP_LOCK_BOOTPAIRS = 8'h3c;
  localparam logic [7:0] LFP_LOCK_RST = 8'hff;

  // ==========================================================================
  // Fuse byte fields.
  localparam logic [7:0] LFP_FEXT_UNUSED = 8'hf0;
  localparam logic [7:0] LFP_FEXT_KEEP = 8'h08;
  localparam logic [7:0] LFP_FEXT_RST = 8'hfe;
  localparam logic [7:0] LFP_FHIGH_RST = 8'h99;
  localparam logic [7:0] LFP_FLOW_RST = 8'h62;
  localparam int LFP_FH_DEBUG = 7;
  localparam int LFP_FH_JTAG = 6;
  localparam int LFP_FH_SERIAL = 5;
  localparam int LFP_FH_WDOG = 4;

  // ==========================================================================
  // Programming interface carriers.
  typedef enum logic [1:0] {LFP_IF_PARALLEL, LFP_IF_JTAG, LFP_IF_SERIAL, LFP_IF_NONE} lfp_iface_t;

  typedef enum logic [3:0] {
    LFP_CMD_CHIP_ERASE,
    LFP_CMD_FLASH_WRITE,
    LFP_CMD_FLASH_READ,
    LFP_CMD_EEPROM_WRITE,
    LFP_CMD_EEPROM_READ,
    LFP_CMD_LOCK_WRITE,
    LFP_CMD_LOCK_READ,
    LFP_CMD_FEXT_WRITE,
    LFP_CMD_FHIGH_WRITE,
    LFP_CMD_FLOW_WRITE,
    LFP_CMD_FEXT_READ,
    LFP_CMD_FHIGH_READ,
    LFP_CMD_FLOW_READ
  } lfp_cmd_t;

  typedef enum logic [1:0] {LFP_MODE_OPEN, LFP_MODE_NOPROG, LFP_MODE_NOVERIFY} lfp_lock_mode_t;

  typedef struct packed {
    logic valid;
    lfp_iface_t iface;
    lfp_cmd_t cmd;
    logic [7:0] data;
  } lfp_prog_req_t;

  typedef struct packed {
    logic done;
    logic denied;
    logic [7:0] rdata;
  } lfp_prog_rsp_t;

  // Processor access to be checked: a store, a load, and where it runs.
  typedef struct packed {
    logic store;
    logic load;
    logic target_boot;
    logic exec_boot;
    logic vectors_boot;
  } lfp_cpu_req_t;

  typedef struct packed {
    logic store_allow;
    logic load_allow;
    logic irq_mask;
  } lfp_cpu_perm_t;

endpackage

/* tb/lfp_top_assertions.sv */
// Checker of the lock and fuse protection block on its top-level ports.
// Assumes a bus master that holds each request until waitrequest is low.
module lfp_top_assertions (
  // Clock and reset.
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // Register bus.
  input wire logic [7:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic AVS_WAITREQUEST_O,
  // Programming and processor ports.
  input wire lfp_pkg::lfp_prog_req_t PROG_REQ_I,
  input wire lfp_pkg::lfp_prog_rsp_t PROG_RSP_O,
  input wire lfp_pkg::lfp_cpu_req_t CPU_REQ_I,
  input wire lfp_pkg::lfp_cpu_perm_t CPU_PERM_O,
  // Row select and fuse decode.
  input wire logic [1:0] ROW_SEL_O,
  input wire logic ROW_USER_O,
  input wire logic [2:0] BROWNOUT_LEVEL_O
);
  timeunit 1ns;
  timeprecision 1ps;
  import lfp_pkg::*;
  // ==========================================================================
  // Properties.
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  a_resp_latency: assert property (PROG_REQ_I.valid |=> PROG_RSP_O.done)
    else $error("No answer one cycle after a request.");
  a_resp_cause: assert property (PROG_RSP_O.done |-> $past(PROG_REQ_I.valid))
    else $error("Answer without a request.");
  a_deny_done: assert property (PROG_RSP_O.denied |-> PROG_RSP_O.done)
    else $error("Refusal outside an answer.");
  a_store_gated: assert property (CPU_PERM_O.store_allow |-> CPU_REQ_I.store)
    else $error("Store allowed without a store.");
  a_local_load: assert property (CPU_REQ_I.load && (CPU_REQ_I.target_boot == CPU_REQ_I.exec_boot)
    |-> CPU_PERM_O.load_allow) else $error("Load from own section refused.");
  a_irq_foreign: assert property (CPU_PERM_O.irq_mask |-> CPU_REQ_I.exec_boot != CPU_REQ_I.vectors_boot)
    else $error("Interrupts masked in the vector section.");
  a_row_user: assert property (ROW_USER_O == (ROW_SEL_O != 2'h0))
    else $error("User row flag wrong.");
  a_row_by_write: assert property ($changed(ROW_SEL_O) |-> ($past(AVS_WRITE_I) && !$past(AVS_WAITREQUEST_O)
    && ($past(AVS_ADDRESS_I) == LFP_OFS_ROW_CTRL))) else $error("Row select moved without a write.");
  a_one_wait: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
    else $error("Bus answer late.");
  a_fuse_hold: assert property (!$past(PROG_REQ_I.valid) |-> $stable(BROWNOUT_LEVEL_O))
    else $error("Fuse output moved without a request.");
  c_denied: cover property (PROG_RSP_O.denied);
  c_irq: cover property (CPU_PERM_O.irq_mask);
  c_row_user: cover property (ROW_USER_O);
endmodule // lfp_top_assertions

bind lfp_top lfp_top_assertions u_lfp_top_assertions (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .PROG_REQ_I(PROG_REQ_I),
  .PROG_RSP_O(PROG_RSP_O), .CPU_REQ_I(CPU_REQ_I), .CPU_PERM_O(CPU_PERM_O), .ROW_SEL_O(ROW_SEL_O),
  .ROW_USER_O(ROW_USER_O), .BROWNOUT_LEVEL_O(BROWNOUT_LEVEL_O)
);

/* tb/lfp_partner.sv */
// Model of the processor core and the programming interfaces facing the block.
// Assumes its tasks are called from one bench process at a time.
module lfp_partner (
  // Clock.
  input wire logic clk_i,
  // Requests toward the block.
  output lfp_pkg::lfp_prog_req_t prog_req_o,
  output lfp_pkg::lfp_cpu_req_t cpu_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import lfp_pkg::*;
  initial
  begin
    prog_req_o = '0;
    cpu_req_o = '0;
  end
  // ==========================================================================
  // Requests.
  // Released data shows its inverse, so a stale byte can never pass for a new one.
  task automatic send(input lfp_iface_t ifc, input lfp_cmd_t c, input logic [7:0] d);
    @(posedge clk_i);
    prog_req_o <= '{1'b1, ifc, c, d};
    @(posedge clk_i);
    prog_req_o.valid <= 1'b0;
    prog_req_o.data <= ~d;
  endtask
  task automatic cpu(input logic [4:0] r);
    @(posedge clk_i);
    cpu_req_o <= r;
  endtask
endmodule // lfp_partner

/* tb/test_lfp_top.sv */
// Self-checking bench of the lock and fuse protection block.
// Assumes lfp_partner drives the programming and processor ports.
module test_lfp_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lfp_pkg::*;
  logic clk = 1'b0;
  logic rst_n;
  logic [7:0] adr;
  logic rd, wr, waitreq, row_user, dbg, jtag, ser, wdog;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic [1:0] row_sel;
  logic [2:0] bod;
  lfp_prog_req_t preq;
  lfp_prog_rsp_t prsp;
  lfp_cpu_req_t creq;
  lfp_cpu_perm_t cperm;
  int errors = 0, checks_done = 0, seed = 62, cycles = 0;
  logic [31:0] bq[$];
  logic [9:0] pq[$];
  logic [9:0] pe;
  always #4 clk = ~clk;
  lfp_top u_lfp_top (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .PROG_REQ_I(preq), .PROG_RSP_O(prsp), .CPU_REQ_I(creq), .CPU_PERM_O(cperm), .ROW_SEL_O(row_sel),
    .ROW_USER_O(row_user), .BROWNOUT_LEVEL_O(bod), .DEBUG_EN_O(dbg), .JTAG_EN_O(jtag),
    .SERIAL_DL_EN_O(ser), .WDOG_FORCED_O(wdog)
  );
  lfp_partner u_lfp_partner (.clk_i(clk), .prog_req_o(preq), .cpu_req_o(creq));
  // ==========================================================================
  // Tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wdata <= d;
    be <= b;
    @(posedge clk);
    while (waitreq !== 1'b0) @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    bq.push_back(e);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask
  // The top bit of a note marks read data that the bench cannot know.
  task automatic pg(input lfp_cmd_t c, input logic [7:0] d, input logic dn, input logic [7:0] r, input logic nc);
    pq.push_back({nc, dn, r});
    u_lfp_partner.send(lfp_iface_t'(2'($unsigned($random(seed)) % 3)), c, d);
  endtask
  function automatic logic [2:0] perm(input logic [4:0] r, input logic [1:0] bp, input logic [1:0] ap);
    logic [1:0] p;
    p = r[2] ? bp : ap;
    return {r[4] & p[0], r[3] & ((r[2] == r[1]) | p[1]), (~r[1] & r[0] & ~ap[1]) | (r[1] & ~r[0] & ~bp[1])};
  endfunction
  // ==========================================================================
  // Monitor and timeout.
  // The timeout comes last so that nothing runs after the closing report.
  always @(posedge clk)
  begin
    cycles++;
    if (rd === 1'b1 && waitreq === 1'b0)
      check(rdata, bq.pop_front());
    if (prsp.done === 1'b1)
    begin
      pe = pq.pop_front();
      check({23'h0, prsp.denied, prsp.rdata}, {23'h0, pe[8], pe[9] ? prsp.rdata : pe[7:0]});
    end
    if (cycles == 5000)
    begin
      errors++;
      summarize();
    end
  end
  // ==========================================================================
  // Scenarios.
  initial
  begin
    {rst_n, adr, rd, wr, wdata, be} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdx(LFP_OFS_LOCK, 32'hff);
    rdx(LFP_OFS_FUSE_EXT, 32'hfe);
    rdx(LFP_OFS_FUSE_HIGH, 32'h99);
    rdx(LFP_OFS_STATUS, 32'h0);
    rdx(8'h20, 32'h0);
    bus(1'b1, LFP_OFS_FUSE_EXT, 32'h0, 4'hf);
    rdx(LFP_OFS_FUSE_EXT, 32'hfe);
    @(negedge clk);
    check({25'h0, bod, dbg, jtag, ser, wdog}, {25'h0, 7'h66});
    $display("test reset_values done");
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, LFP_OFS_ROW_CTRL, {24'h0, 1'b0, i[2], i[1:0], 4'($random(seed))}, 4'h1);
      @(negedge clk);
      check({29'h0, row_user, row_sel}, {29'h0, i[2] && i[1:0] != 2'h0, i[2] ? i[1:0] : 2'h0});
    end
    bus(1'b1, LFP_OFS_ROW_CTRL, 32'h0, 4'h0);
    @(negedge clk);
    check({30'h0, row_sel}, 32'h3);
    $display("test row_select done");
    for (int b = 0; b < 4; b++)
      for (int a = 0; a < 4; a++)
      begin
        pg(LFP_CMD_CHIP_ERASE, 8'h00, 1'b0, 8'hff, 1'b0);
        bus(1'b1, LFP_OFS_LOCK, {24'h0, 2'b11, b[1:0], a[1:0], 2'b11}, 4'hf);
        rdx(LFP_OFS_LOCK, {24'h0, 2'b11, b[1:0], a[1:0], 2'b11});
        for (int r = 0; r < 32; r++)
        begin
          u_lfp_partner.cpu(5'(r));
          @(negedge clk);
          check({29'h0, cperm}, {29'h0, perm(5'(r), b[1:0], a[1:0])});
        end
      end
    $display("test section_locks done");
    pg(LFP_CMD_CHIP_ERASE, 8'h00, 1'b0, 8'hff, 1'b0);
    pg(LFP_CMD_FEXT_WRITE, 8'h00, 1'b0, 8'hff, 1'b0);
    pg(LFP_CMD_FEXT_READ, 8'h00, 1'b0, 8'hf8, 1'b0);
    pg(LFP_CMD_LOCK_WRITE, 8'hfe, 1'b0, 8'hff, 1'b0);
    rdx(LFP_OFS_STATUS, 32'h1);
    pg(LFP_CMD_FLASH_WRITE, 8'($random(seed)), 1'b1, 8'hff, 1'b0);
    pg(LFP_CMD_EEPROM_WRITE, 8'($random(seed)), 1'b1, 8'hff, 1'b0);
    pg(LFP_CMD_FLASH_READ, 8'h00, 1'b0, 8'h00, 1'b1);
    pg(LFP_CMD_FHIGH_WRITE, 8'h00, 1'b1, 8'hff, 1'b0);
    pg(LFP_CMD_FHIGH_READ, 8'h00, 1'b0, 8'h99, 1'b0);
    pg(LFP_CMD_LOCK_WRITE, 8'hfc, 1'b0, 8'hff, 1'b0);
    rdx(LFP_OFS_STATUS, 32'h2);
    pg(LFP_CMD_EEPROM_READ, 8'h00, 1'b1, 8'h00, 1'b1);
    pg(LFP_CMD_FLASH_READ, 8'h00, 1'b1, 8'h00, 1'b1);
    pg(LFP_CMD_LOCK_WRITE, 8'hef, 1'b1, 8'hff, 1'b0);
    pg(LFP_CMD_LOCK_READ, 8'h00, 1'b0, 8'hfc, 1'b0);
    pg(LFP_CMD_CHIP_ERASE, 8'h00, 1'b0, 8'hff, 1'b0);
    pg(LFP_CMD_LOCK_READ, 8'h00, 1'b0, 8'hff, 1'b0);
    rdx(LFP_OFS_STATUS, 32'h0);
    rdx(LFP_OFS_FUSE_EXT, 32'hf8);
    @(negedge clk);
    check({25'h0, bod, dbg, jtag, ser, wdog}, {25'h0, 7'h06});
    $display("test lock_modes done");
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule // test_lfp_top
